/* verilog/tsic_pkg.sv */
`default_nettype none
package tsic_pkg;

    // Widths of the controller and of its register port.
    localparam int NUM_SRC = 10;
    localparam int IDX_W = 4;
    localparam int LVL_W = 2;
    localparam int NUM_LVL = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int VEC_W = 16;
    localparam int NUM_CMP = 5;
    localparam int EN_W = 11;

    // Source indices, numbered in equal-level polling order.
    localparam logic [IDX_W-1:0] IDX_EXT_A = 4'h0;
    localparam logic [IDX_W-1:0] IDX_TIMER_A = 4'h1;
    localparam logic [IDX_W-1:0] IDX_EXT_B = 4'h2;
    localparam logic [IDX_W-1:0] IDX_TIMER_B = 4'h3;
    localparam logic [IDX_W-1:0] IDX_COUNTER = 4'h4;
    localparam logic [IDX_W-1:0] IDX_SERIAL = 4'h5;
    localparam logic [IDX_W-1:0] IDX_TIMER_C = 4'h6;
    localparam logic [IDX_W-1:0] IDX_CAN = 4'h7;
    localparam logic [IDX_W-1:0] IDX_CONV = 4'h8;
    localparam logic [IDX_W-1:0] IDX_CAN_TIMER = 4'h9;

    // Fixed vector of each source, entry 0 at the low end.
    localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VECTOR = {
        16'h004b, 16'h0043, 16'h003b, 16'h002b, 16'h0023,
        16'h0033, 16'h001b, 16'h0013, 16'h000b, 16'h0003};

    // Bit of each source inside the joined {reg1[2:0], reg0[7:0]} word.
    localparam logic [NUM_SRC-1:0][3:0] SRC_BITPOS = {
        4'ha, 4'h9, 4'h8, 4'h5, 4'h4, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0};

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] REG_ENABLE0 = 4'h0;
    localparam logic [ADDR_W-1:0] REG_ENABLE1 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_PRIO_LOW0 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PRIO_HIGH0 = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PRIO_LOW1 = 4'h4;
    localparam logic [ADDR_W-1:0] REG_PRIO_HIGH1 = 4'h5;
    localparam logic [ADDR_W-1:0] REG_PENDING0 = 4'h6;
    localparam logic [ADDR_W-1:0] REG_PENDING1 = 4'h7;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

    // Field positions and reset values.
    localparam int GLOBAL_EN_BIT = 7;
    localparam int CONV_EN_BIT = 1;
    localparam int STATUS_REQ_BIT = 7;
    localparam logic [DATA_W-1:0] REG0_RST = 8'h00;
    localparam logic [2:0] REG1_RST = 3'h0;

    // Flags coming in from the peripherals.
    typedef struct packed {
        logic ext_pin_req_a;
        logic ext_pin_req_b;
        logic timer_a_overflow_flag;
        logic timer_b_overflow_flag;
        logic timer_c_overflow_flag;
        logic counter_array_overflow_flag;
        logic [NUM_CMP-1:0] compare_match_flag;
        logic serial_receive_done_flag;
        logic serial_transmit_done_flag;
        logic can_tx_done_flag;
        logic can_rx_done_flag;
        logic can_error_flag;
        logic can_buffer_overrun_flag;
        logic can_timer_overrun_flag;
        logic conversion_done_flag;
    } tsic_src_t;

    // One register port cycle.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } tsic_bus_t;

    // Request offered to the core.
    typedef struct packed {
        logic req;
        logic [IDX_W-1:0] src;
        logic [LVL_W-1:0] level;
        logic [VEC_W-1:0] vector;
    } tsic_core_t;

    // Reorders a register pair into one bit per source in polling order.
    function automatic logic [NUM_SRC-1:0] gather(input logic [EN_W-1:0] word);
        logic [NUM_SRC-1:0] res;
        res = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            res[i] = word[SRC_BITPOS[i]];
        end
        return res;
    endfunction : gather

endpackage : tsic_pkg
`default_nettype wire

/* verilog/tsic_pick.sv */
`default_nettype none
module tsic_pick (
    input wire logic [tsic_pkg::NUM_SRC-1:0] req,
    input wire logic [tsic_pkg::NUM_SRC-1:0][tsic_pkg::LVL_W-1:0] lvl,
    output logic valid,
    output logic [tsic_pkg::IDX_W-1:0] idx,
    output logic [tsic_pkg::LVL_W-1:0] level
);
    import tsic_pkg::*;

    // Scans in polling order; only a strictly higher level displaces the
    // current pick, so earlier sources win ties.
    always_comb begin
        valid = 1'b0;
        idx = '0;
        level = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && (!valid || lvl[i] > level)) begin // see RULE7 see RULE8
                valid = 1'b1;
                idx = IDX_W'(i);
                level = lvl[i];
            end
        end
    end

endmodule : tsic_pick
`default_nettype wire

/* verilog/tsic_inservice.sv */
`default_nettype none
module tsic_inservice (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [tsic_pkg::LVL_W-1:0] push_lvl,
    input wire logic pop,
    output logic [tsic_pkg::NUM_LVL-1:0] active,
    output logic busy,
    output logic [tsic_pkg::LVL_W-1:0] top_lvl
);
    import tsic_pkg::*;

    logic [NUM_LVL-1:0] active_r;
    logic [NUM_LVL-1:0] top_bit;

    // Finds the highest level still in service.
    always_comb begin
        top_lvl = '0;
        top_bit = '0;
        for (int i = 0; i < NUM_LVL; i++) begin
            if (active_r[i]) begin
                top_lvl = LVL_W'(i);
            end
        end
        top_bit[top_lvl] = active_r[top_lvl];
    end

    // A return releases the top level; an accepted vector marks its level.
    always_ff @(posedge clk) begin
        if (rst) begin
            active_r <= '0;
        end else begin
            active_r <= (active_r & ~(pop ? top_bit : '0)) | (push ? (4'h1 << push_lvl) : 4'h0); // see RULE13
        end
    end

    assign active = active_r;
    assign busy = |active_r;

endmodule : tsic_inservice
`default_nettype wire

/* verilog/tsic_top.sv */
// Behaviour
// RULE1 - Ten vectored sources are collected: two pins, three timers, serial, counter array, CAN, CAN timer, converter.
// RULE2 - A source whose own enable bit is clear is never offered to the core.
// RULE3 - Clearing the global enable blocks every source at once.
// RULE4 - Each source takes level 0 to 3 from its high and low priority bits, 3 being the highest.
// RULE5 - While a routine runs, only a strictly higher level may preempt it.
// RULE6 - A routine at the highest level is never preempted.
// RULE7 - Of simultaneous requests the one with the higher level is served.
// RULE8 - Equal levels are resolved by the fixed polling order of the sources.
// RULE9 - Every source has its fixed vector address.
// RULE10 - Any CAN transmit, receive, error or overrun flag raises the CAN request.
// RULE11 - Bit 7 of the first enable register is the global enable; when set the individual bits decide.
// RULE12 - The converter requests while its done flag and its enable bit are both set.
// RULE13 - Levels in service are tracked and released on return, and requests compare against the highest one.
//
// The address map and the address-and-strobe port were left to the implementer.
`default_nettype none
module tsic_top (
    input wire logic clk,
    input wire logic rst,
    input wire tsic_pkg::tsic_src_t src_i,
    input wire tsic_pkg::tsic_bus_t bus_i,
    input wire logic irq_ack,
    input wire logic irq_return,
    output tsic_pkg::tsic_core_t core_r,
    output logic [tsic_pkg::DATA_W-1:0] rdata_r
);
    import tsic_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_TAKEN} tsic_state_t;

    logic [DATA_W-1:0] request_enable0_r;
    logic [2:0] request_enable1_r;
    logic [DATA_W-1:0] priority_low_bits0_r;
    logic [DATA_W-1:0] priority_high_bits0_r;
    logic [2:0] priority_low_bits1_r;
    logic [2:0] priority_high_bits1_r;
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] pend_r;
    logic [NUM_SRC-1:0] en_vec;
    logic [NUM_SRC-1:0] eligible;
    logic [NUM_SRC-1:0][LVL_W-1:0] lvl;
    logic global_request_enable;
    logic cand_valid;
    logic [IDX_W-1:0] cand_idx;
    logic [LVL_W-1:0] cand_lvl;
    logic [NUM_LVL-1:0] active;
    logic busy;
    logic [LVL_W-1:0] top_lvl;
    logic allow;
    tsic_state_t state_r;
    tsic_state_t state_nxt;
    tsic_core_t core_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic [NUM_SRC-1:0] eligible_q_r;
    logic [NUM_SRC-1:0][LVL_W-1:0] lvl_q_r;
    logic [LVL_W-1:0] elig_max_q;

    // Software writes to enable and priority registers; read-only offsets ignore writes.
    always_ff @(posedge clk) begin
        if (rst) begin
            request_enable0_r <= REG0_RST;
            request_enable1_r <= REG1_RST;
            priority_low_bits0_r <= REG0_RST;
            priority_high_bits0_r <= REG0_RST;
            priority_low_bits1_r <= REG1_RST;
            priority_high_bits1_r <= REG1_RST;
        end else if (bus_i.we) begin
            case (bus_i.addr)
                REG_ENABLE0: begin
                    request_enable0_r <= bus_i.wdata;
                end
                REG_ENABLE1: begin
                    request_enable1_r <= bus_i.wdata[2:0];
                end
                REG_PRIO_LOW0: begin
                    priority_low_bits0_r <= bus_i.wdata;
                end
                REG_PRIO_HIGH0: begin
                    priority_high_bits0_r <= bus_i.wdata;
                end
                REG_PRIO_LOW1: begin
                    priority_low_bits1_r <= bus_i.wdata[2:0];
                end
                REG_PRIO_HIGH1: begin
                    priority_high_bits1_r <= bus_i.wdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Raw request of each source in polling order.
    always_comb begin
        raw_req = '0;
        raw_req[IDX_EXT_A] = src_i.ext_pin_req_a; // see RULE1
        raw_req[IDX_TIMER_A] = src_i.timer_a_overflow_flag;
        raw_req[IDX_EXT_B] = src_i.ext_pin_req_b;
        raw_req[IDX_TIMER_B] = src_i.timer_b_overflow_flag;
        raw_req[IDX_COUNTER] = src_i.counter_array_overflow_flag | (|src_i.compare_match_flag);
        raw_req[IDX_SERIAL] = src_i.serial_receive_done_flag | src_i.serial_transmit_done_flag;
        raw_req[IDX_TIMER_C] = src_i.timer_c_overflow_flag;
        raw_req[IDX_CAN] = src_i.can_tx_done_flag | src_i.can_rx_done_flag | src_i.can_error_flag
            | src_i.can_buffer_overrun_flag; // see RULE10
        raw_req[IDX_CONV] = src_i.conversion_done_flag; // see RULE12
        raw_req[IDX_CAN_TIMER] = src_i.can_timer_overrun_flag;
    end

    // Enables and levels are reordered into polling order.
    assign global_request_enable = request_enable0_r[GLOBAL_EN_BIT]; // see RULE11
    assign en_vec = gather({request_enable1_r, request_enable0_r}) & {NUM_SRC{global_request_enable}}; // see RULE3
    assign eligible = raw_req & en_vec; // see RULE2 see RULE12

    // Each level is the high bit above the low bit of the source.
    always_comb begin
        logic [NUM_SRC-1:0] lo;
        logic [NUM_SRC-1:0] hi;
        lo = gather({priority_low_bits1_r, priority_low_bits0_r});
        hi = gather({priority_high_bits1_r, priority_high_bits0_r});
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl[i] = {hi[i], lo[i]}; // see RULE4
        end
    end

    // Picks the best eligible request.
    tsic_pick u_pick (
        .req(eligible),
        .lvl(lvl),
        .valid(cand_valid),
        .idx(cand_idx),
        .level(cand_lvl)
    );

    // Keeps the levels that the core is serving.
    tsic_inservice u_inservice (
        .clk(clk),
        .rst(rst),
        .push(irq_ack && core_r.req),
        .push_lvl(core_r.level),
        .pop(irq_return),
        .active(active),
        .busy(busy),
        .top_lvl(top_lvl)
    );

    // Only a strictly higher level than the top one in service may preempt.
    assign allow = cand_valid && (!busy || cand_lvl > top_lvl); // see RULE5 see RULE6 see RULE13

    // Offer sequence: offer, taken by the core, one cycle for the level to settle.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (allow) begin
                    state_nxt = ST_OFFER;
                end
            end
            ST_OFFER: begin
                if (irq_ack) begin
                    state_nxt = ST_TAKEN;
                end else if (!allow) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_TAKEN: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // The offered vector follows the current pick until the core takes it.
    always_comb begin
        core_nxt = '0;
        if (state_nxt == ST_OFFER) begin
            core_nxt.req = 1'b1;
            core_nxt.src = cand_idx;
            core_nxt.level = cand_lvl;
            core_nxt.vector = SRC_VECTOR[cand_idx]; // see RULE9
        end
    end

    // State and core outputs.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            core_r <= '0;
        end else begin
            state_r <= state_nxt;
            core_r <= core_nxt;
        end
    end

    // Pending view for software and copies used by the checks below.
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= '0;
            eligible_q_r <= '0;
            lvl_q_r <= '0;
        end else begin
            pend_r <= raw_req;
            eligible_q_r <= allow ? eligible : '0;
            lvl_q_r <= lvl;
        end
    end

    // Highest level among the requests that were eligible when the offer was chosen.
    always_comb begin
        elig_max_q = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (eligible_q_r[i] && lvl_q_r[i] > elig_max_q) begin
                elig_max_q = lvl_q_r[i];
            end
        end
    end

    // Read data for the cycle after the read strobe; unmapped offsets read zero.
    always_comb begin
        rdata_nxt = '0;
        case (bus_i.addr)
            REG_ENABLE0: rdata_nxt = request_enable0_r;
            REG_ENABLE1: rdata_nxt = {5'h00, request_enable1_r};
            REG_PRIO_LOW0: rdata_nxt = priority_low_bits0_r;
            REG_PRIO_HIGH0: rdata_nxt = priority_high_bits0_r;
            REG_PRIO_LOW1: rdata_nxt = {5'h00, priority_low_bits1_r};
            REG_PRIO_HIGH1: rdata_nxt = {5'h00, priority_high_bits1_r};
            REG_PENDING0: rdata_nxt = pend_r[7:0];
            REG_PENDING1: rdata_nxt = {6'h00, pend_r[9:8]};
            REG_STATUS: rdata_nxt = {core_r.req, 3'h0, active};
            default: rdata_nxt = '0;
        endcase
    end

    // Read data register; it holds zero outside a read answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= bus_i.re ? rdata_nxt : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence offer_s;
        core_r.req;
    endsequence

    sequence no_offer_s;
        !core_r.req;
    endsequence

    enable_gate_a: assert property (offer_s |-> $past(en_vec[cand_idx])) // see RULE2
        else $error("Offered a source whose enable was clear.");

    global_block_a: assert property (!global_request_enable |=> no_offer_s) // see RULE3
        else $error("Offer made while the global enable was clear.");

    higher_level_a: assert property (offer_s |-> core_r.level == elig_max_q) // see RULE7
        else $error("A higher level request was passed over.");

    tie_order_a: assert property (offer_s |-> core_r.src == $past(cand_idx) && core_r.level == $past(cand_lvl)) // see RULE8
        else $error("Offer does not match the polled pick.");

    vector_map_a: assert property (offer_s |-> core_r.vector == SRC_VECTOR[core_r.src]) // see RULE9
        else $error("Vector does not belong to the offered source.");

    preempt_only_a: assert property (offer_s |-> $past(active) == '0 || core_r.level > $past(top_lvl)) // see RULE5
        else $error("Offer at a level not above the one in service.");

    top_locked_a: assert property (active[3] && !irq_return |=> no_offer_s) // see RULE6
        else $error("Offer made while the highest level was in service.");

    can_merge_a: assert property ((src_i.can_error_flag || src_i.can_buffer_overrun_flag) |=> pend_r[IDX_CAN]) // see RULE10
        else $error("CAN flag did not raise the CAN request.");

    conv_gate_a: assert property ((offer_s and (core_r.src == IDX_CONV)) |->
        $past(src_i.conversion_done_flag && request_enable1_r[CONV_EN_BIT])) // see RULE12
        else $error("Converter offered without flag and enable.");

    release_top_a: assert property (irq_return && busy && !(irq_ack && core_r.req) |=>
        $countones(active) == $countones($past(active)) - 1 && !active[$past(top_lvl)]) // see RULE13
        else $error("Return did not release the top level.");

    take_gap_a: assert property (offer_s ##0 irq_ack |=> no_offer_s ##1 (active != '0)) // see RULE13
        else $error("Accepted offer was not recorded in service.");

endmodule : tsic_top
`default_nettype wire

/* bench/tsic_core_model.sv */
`default_nettype none
module tsic_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire tsic_pkg::tsic_core_t core,
    input wire logic [3:0] ack_wait,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic irq_return,
    output tsic_pkg::tsic_core_t taken,
    output logic [7:0] n_taken
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsic_pkg::*;

    logic [3:0] wait_r;

    // Acknowledges an offer after ack_wait cycles and keeps what the ack cycle showed.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ack <= 1'b0;
            irq_return <= 1'b0;
            taken <= '0;
            n_taken <= 8'h00;
            wait_r <= 4'h0;
        end else begin
            irq_ack <= 1'b0;
            irq_return <= ret_cmd; // A return is one cycle long.
            if (irq_ack) begin
                taken <= core;
                n_taken <= n_taken + 8'h01;
                wait_r <= 4'h0;
            end else if (core.req) begin
                if (wait_r == ack_wait) begin
                    irq_ack <= 1'b1;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end

endmodule : tsic_core_model
`default_nettype wire

/* bench/tb_tsic_top.sv */
`default_nettype none
`define check_eq(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module tb_tsic_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tsic_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    tsic_src_t src_i;
    tsic_bus_t bus_i;
    logic irq_ack;
    logic irq_return;
    tsic_core_t core_r;
    tsic_core_t taken;
    logic [7:0] rdata_r;
    logic [7:0] n_taken;
    logic [3:0] ack_wait;
    logic ret_cmd;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int exp_n = 0;
    // Expected vector and enable bit position of each source, in polling order.
    localparam logic [9:0][15:0] exp_vec = {16'h004b, 16'h0043, 16'h003b, 16'h002b, 16'h0023,
        16'h0033, 16'h001b, 16'h0013, 16'h000b, 16'h0003};
    localparam logic [9:0][3:0] bitpos = {4'ha, 4'h9, 4'h8, 4'h5, 4'h4, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0};

    tsic_top tsic_top_inst (.clk(clk), .rst(rst), .src_i(src_i), .bus_i(bus_i), .irq_ack(irq_ack),
        .irq_return(irq_return), .core_r(core_r), .rdata_r(rdata_r));
    tsic_core_model tsic_core_model_inst (.clk(clk), .rst(rst), .core(core_r), .ack_wait(ack_wait),
        .ret_cmd(ret_cmd), .irq_ack(irq_ack), .irq_return(irq_return), .taken(taken), .n_taken(n_taken));

    // Clock and hang guard.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    // Prints the verdict and ends the run.
    task automatic results();
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Register port cycles.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_i.we <= 1'b1;
        bus_i.addr <= a;
        bus_i.wdata <= d;
        @(posedge clk);
        bus_i.we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_i.re <= 1'b1;
        bus_i.addr <= a;
        @(posedge clk);
        bus_i.re <= 1'b0;
        #1;
        `check_eq(rdata_r, d)
    endtask : rd

    // Drives one flag; 10 to 12 are the further CAN flags.
    task automatic set_src(input int i, input logic v);
        case (i)
            0: src_i.ext_pin_req_a <= v;
            1: src_i.timer_a_overflow_flag <= v;
            2: src_i.ext_pin_req_b <= v;
            3: src_i.timer_b_overflow_flag <= v;
            4: src_i.counter_array_overflow_flag <= v;
            5: src_i.serial_receive_done_flag <= v;
            6: src_i.timer_c_overflow_flag <= v;
            7: src_i.can_tx_done_flag <= v;
            8: src_i.conversion_done_flag <= v;
            9: src_i.can_timer_overrun_flag <= v;
            10: src_i.can_rx_done_flag <= v;
            11: src_i.can_error_flag <= v;
            default: src_i.can_buffer_overrun_flag <= v;
        endcase
    endtask : set_src
    task automatic raise(input int i);
        @(posedge clk);
        set_src(i, 1'b1);
    endtask : raise

    // Writes enables and levels given per source in polling order.
    task automatic cfg(input logic [9:0] en, input logic glob, input logic [9:0][1:0] lvl);
        logic [10:0] e;
        logic [10:0] lo;
        logic [10:0] hi;
        e = '0;
        lo = '0;
        hi = '0;
        for (int i = 0; i < 10; i++) begin
            e[bitpos[i]] = en[i];
            lo[bitpos[i]] = lvl[i][0];
            hi[bitpos[i]] = lvl[i][1];
        end
        wr(REG_ENABLE0, {glob, e[6:0]});
        wr(REG_ENABLE1, {5'h00, e[10:8]});
        wr(REG_PRIO_LOW0, {1'b0, lo[6:0]});
        wr(REG_PRIO_HIGH0, {1'b0, hi[6:0]});
        wr(REG_PRIO_LOW1, {5'h00, lo[10:8]});
        wr(REG_PRIO_HIGH1, {5'h00, hi[10:8]});
    endtask : cfg

    // Waits for the core to take the next vector and judges it.
    task automatic expect_take(input logic [3:0] i, input logic [1:0] l);
        int k;
        k = 0;
        exp_n++;
        while (n_taken !== exp_n[7:0] && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        `check_eq(n_taken, exp_n[7:0])
        `check_eq(taken.src, i)
        `check_eq(taken.vector, exp_vec[i])
        `check_eq(taken.level, l)
    endtask : expect_take
    task automatic no_take();
        repeat (6) @(posedge clk);
        #1;
        `check_eq(n_taken, exp_n[7:0])
        `check_eq(core_r.req, 1'b0)
    endtask : no_take
    task automatic clr_ret(input int i);
        @(posedge clk);
        set_src(i, 1'b0);
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : clr_ret

    // Reset values, stored widths, unmapped place and raw flags.
    task automatic s_regs();
        rd(REG_ENABLE0, 8'h00);
        wr(REG_ENABLE1, 8'hff);
        rd(REG_ENABLE1, 8'h07);
        wr(REG_PRIO_HIGH0, 8'h5a);
        rd(REG_PRIO_HIGH0, 8'h5a);
        wr(4'hc, 8'hff);
        rd(4'hc, 8'h00);
        @(posedge clk);
        set_src(2, 1'b1);
        set_src(6, 1'b1);
        rd(REG_PENDING0, 8'h44);
        @(posedge clk);
        set_src(2, 1'b0);
        set_src(6, 1'b0);
    endtask : s_regs

    // All ten sources at level 0 at once come out in polling order.
    task automatic s_poll();
        cfg(10'h3ff, 1'b1, '0);
        @(posedge clk);
        for (int i = 0; i < 10; i++) set_src(i, 1'b1);
        for (int i = 0; i < 10; i++) begin
            expect_take(i[3:0], 2'h0);
            no_take();
            clr_ret(i);
        end
    endtask : s_poll

    // Levels, preemption and release on return, with a slow core.
    task automatic s_levels();
        logic [9:0][1:0] lv;
        lv = '0;
        lv[1] = 2'h1;
        lv[2] = 2'h2;
        lv[3] = 2'h3;
        lv[4] = 2'h3;
        ack_wait <= 4'h3;
        cfg(10'h3ff, 1'b1, lv);
        @(posedge clk);
        set_src(0, 1'b1);
        set_src(2, 1'b1);
        expect_take(4'h2, 2'h2);
        raise(1);
        no_take();
        raise(3);
        expect_take(4'h3, 2'h3);
        raise(4);
        no_take();
        rd(REG_STATUS, 8'h0c);
        clr_ret(3);
        expect_take(4'h4, 2'h3);
        clr_ret(4);
        no_take();
        clr_ret(2);
        expect_take(4'h1, 2'h1);
        clr_ret(1);
        expect_take(4'h0, 2'h0);
        clr_ret(0);
        ack_wait <= 4'h0;
    endtask : s_levels

    // Global and own enables, converter request and every CAN flag.
    task automatic s_enables();
        cfg(10'h3ff, 1'b0, '0);
        raise(0);
        no_take();
        wr(REG_ENABLE0, 8'h80);
        no_take();
        wr(REG_ENABLE0, 8'h81);
        expect_take(4'h0, 2'h0);
        clr_ret(0);
        wr(REG_ENABLE1, 8'h00);
        raise(8);
        no_take();
        wr(REG_ENABLE1, 8'h02);
        expect_take(4'h8, 2'h0);
        clr_ret(8);
        wr(REG_ENABLE1, 8'h01);
        for (int k = 0; k < 4; k++) begin
            raise(k == 0 ? 7 : k + 9);
            expect_take(4'h7, 2'h0);
            clr_ret(k == 0 ? 7 : k + 9);
        end
    endtask : s_enables

    // Main sequence.
    initial begin
        src_i = '0;
        bus_i = '0;
        ack_wait = 4'h0;
        ret_cmd = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        s_regs();
        s_poll();
        s_levels();
        s_enables();
        results();
    end

endmodule : tb_tsic_top
`undef check_eq
`default_nettype wire
